//--- inc/sspe_pkg.sv
// Purpose: Shared constants and code conversions for the serial position encoder link.
// Assumes: A 100 MHz core clock on both ends.
// Notes: Times are kept in their own units; cycle counts derive from them.
package sspe_pkg;
	localparam int CLK_MHZ = 100;
	localparam int POS_MAX_BITS = 16;
	// Monoflop interval, nominal and tolerance.
	localparam int MONO_NOM_US = 20;
	localparam int MONO_TOL_US = 10;
	localparam int MONO_CYC = MONO_NOM_US * CLK_MHZ;
	// The controller waits past the longest interval the far end may use.
	localparam int MONO_MAX_CYC = (MONO_NOM_US + MONO_TOL_US) * CLK_MHZ + 1;
	// Least zero-set pulse width.
	localparam int ZERO_MIN_MS = 100;
	localparam int ZERO_MIN_CYC = ZERO_MIN_MS * 1000 * CLK_MHZ;
	// Serial rate range in kbit/s and the half-period bounds it allows.
	localparam int RATE_MIN_KBPS = 100;
	localparam int RATE_MAX_KBPS = 2000;
	localparam int HALF_MIN = (CLK_MHZ * 1000 + 2 * RATE_MAX_KBPS - 1) / (2 * RATE_MAX_KBPS);
	localparam int HALF_MAX = (CLK_MHZ * 1000) / (2 * RATE_MIN_KBPS);
	// Controller register map (byte addresses).
	localparam int ADDR_W = 5;
	localparam logic [ADDR_W-1:0] REG_CTRL = 5'h00;
	localparam logic [ADDR_W-1:0] REG_STATUS = 5'h04;
	localparam logic [ADDR_W-1:0] REG_POS = 5'h08;
	localparam logic [ADDR_W-1:0] REG_IRQ_STAT = 5'h0C;
	localparam logic [ADDR_W-1:0] REG_IRQ_MASK = 5'h10;
	localparam int CTRL_START_BIT = 0;
	localparam int STAT_BUSY_BIT = 0;
	localparam int IRQ_DONE_BIT = 0;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	function automatic logic [POS_MAX_BITS-1:0] bin2gray(input logic [POS_MAX_BITS-1:0] b);
		return b ^ (b >> 1);
	endfunction: bin2gray

	function automatic logic [POS_MAX_BITS-1:0] gray2bin(input logic [POS_MAX_BITS-1:0] g);
		logic [POS_MAX_BITS-1:0] b;
		b[POS_MAX_BITS-1] = g[POS_MAX_BITS-1];
		for (int i = POS_MAX_BITS - 2; i >= 0; i--) begin
			b[i] = b[i+1] ^ g[i];
		end
		return b;
	endfunction: gray2bin
endpackage: sspe_pkg

//--- inc/sspe_link_if.sv
// Purpose: Synchronous serial link between the position encoder and its controller.
// Assumes: Both lines idle high; the controller owns the clock line.
// Notes: Differential buffering is outside this carrier.
`timescale 1ns/10ps
interface sspe_link_if;
	logic ssi_clk;
	logic ssi_data;
	modport dev(input ssi_clk, output ssi_data);
	modport ctl(output ssi_clk, input ssi_data);
endinterface: sspe_link_if

//--- design/sspe_encoder.sv
// Purpose: Encoder end: position counter, zero-set, indicators and serial shifter.
// Assumes: Link clock and side pins are asynchronous to core_clk.
// Notes: The shaft steps arrive as one-cycle pulses from the sensing logic.
`timescale 1ns/10ps
module sspe_encoder #(
	parameter int BITS = sspe_pkg::POS_MAX_BITS,
	parameter bit GRAY = 1'b1,
	parameter int ZERO_MIN = sspe_pkg::ZERO_MIN_CYC
) (
	// Clock and reset.
	input wire logic core_clk,
	input wire logic rstn,
	// Serial link.
	sspe_link_if.dev link,
	// Shaft step pulses from the sensing logic.
	input wire logic step,
	input wire logic step_cw,
	// Side pins, asynchronous.
	input wire logic dir_sel,
	input wire logic zero_set,
	input wire logic preset_key,
	input wire logic diag_fail,
	// Indicators and observed position.
	output logic led_green,
	output logic led_red,
	output logic [BITS-1:0] position
);
	import sspe_pkg::*;

	if (BITS < 2 || BITS > POS_MAX_BITS) begin : g_bad_bits
		$error("BITS must lie between 2 and the maximum word width");
	end
	if (ZERO_MIN < 1) begin : g_bad_zero
		$error("ZERO_MIN must be at least one cycle");
	end

	localparam int ZW = $clog2(ZERO_MIN + 1);
	localparam int MW = $clog2(MONO_CYC + 1);
	localparam int IW = $clog2(BITS + 1);
	localparam logic [ZW-1:0] ZMAX = ZW'(ZERO_MIN);
	localparam logic [MW-1:0] MMAX = MW'(MONO_CYC);
	localparam logic [IW-1:0] IMAX = IW'(BITS);
	localparam int PIN_W = 5;
	localparam int P_CLK = 4;
	localparam int P_DIR = 3;
	localparam int P_ZERO = 2;
	localparam int P_KEY = 1;
	localparam int P_DIAG = 0;
	// Reset to the idle level of each pin, so no false edge follows reset.
	localparam logic [PIN_W-1:0] PIN_IDLE = PIN_W'((1 << P_CLK) | (1 << P_DIR));

	typedef enum logic [1:0] {
		ST_IDLE = 2'b01,
		ST_SHIFT = 2'b10
	} sspe_link_state_e;

	logic [PIN_W-1:0] pin_s1;
	logic [PIN_W-1:0] pin_s2;
	logic clk_prev;
	logic zero_prev;
	logic key_prev;
	logic [ZW-1:0] zero_cnt;
	logic [MW-1:0] mono_cnt;
	logic [IW-1:0] bit_idx;
	logic [BITS-1:0] shift_word;
	logic data_out;
	sspe_link_state_e state;
	logic clk_fall;
	logic clk_rise;
	logic key_press;
	logic zero_fall_ok;
	logic zero_req;
	logic mono_done;
	logic [POS_MAX_BITS-1:0] pos_code;

	////////////////////////////////////////////////////////////////////////////
	// Every side pin and the link clock pass two flip-flops before any logic looks at them; step and step_cw are used directly.
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			pin_s1 <= PIN_IDLE;
			pin_s2 <= PIN_IDLE;
		end else begin
			pin_s1 <= {link.ssi_clk, dir_sel, zero_set, preset_key, diag_fail};
			pin_s2 <= pin_s1;
		end
	end

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			clk_prev <= 1'b1;
			zero_prev <= 1'b0;
			key_prev <= 1'b0;
		end else begin
			clk_prev <= pin_s2[P_CLK];
			zero_prev <= pin_s2[P_ZERO];
			key_prev <= pin_s2[P_KEY];
		end
	end

	assign clk_fall = clk_prev & ~pin_s2[P_CLK];
	assign clk_rise = ~clk_prev & pin_s2[P_CLK];
	assign key_press = ~key_prev & pin_s2[P_KEY];

	////////////////////////////////////////////////////////////////////////////
	// Zero-set pin: width is measured while high and judged at the falling edge.
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			zero_cnt <= '0;
		end else if (!pin_s2[P_ZERO]) begin
			zero_cnt <= '0;
		end else if (zero_cnt != ZMAX) begin
			zero_cnt <= zero_cnt + 1'b1;
		end
	end

	// A short pulse is ignored, so noise on the pin cannot clear the position.
	assign zero_fall_ok = zero_prev & ~pin_s2[P_ZERO] & (zero_cnt == ZMAX);
	assign zero_req = zero_fall_ok | key_press;

	////////////////////////////////////////////////////////////////////////////
	// Position counter; zeroing wins over a step in the same cycle.
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			position <= '0;
		end else if (zero_req) begin
			position <= '0;
		end else if (step) begin
			if (step_cw == pin_s2[P_DIR]) begin
				position <= position + 1'b1;
			end else begin
				position <= position - 1'b1;
			end
		end
	end

	// The word is as wide as BITS, so it wraps at one revolution.
	assign pos_code = GRAY ? bin2gray(POS_MAX_BITS'(position)) : POS_MAX_BITS'(position);

	////////////////////////////////////////////////////////////////////////////
	// Monoflop: restarted by every falling clock edge, it ends the transfer.
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			mono_cnt <= '0;
		end else if (state == ST_IDLE || clk_fall) begin
			mono_cnt <= '0;
		end else if (mono_cnt != MMAX) begin
			mono_cnt <= mono_cnt + 1'b1;
		end
	end

	// Only a pause with the clock back high counts; a stuck-low line holds.
	assign mono_done = (mono_cnt == MMAX) & pin_s2[P_CLK];

	////////////////////////////////////////////////////////////////////////////
	// Serial shifter. The word rotates, so after the low separator bit the
	// next rising edge starts the same latched word again.
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			state <= ST_IDLE;
			shift_word <= '0;
			bit_idx <= '0;
			data_out <= 1'b1;
		end else begin
			unique case (state)
				ST_IDLE: begin
					data_out <= 1'b1;
					if (clk_fall) begin
						shift_word <= pos_code[BITS-1:0];
						bit_idx <= '0;
						state <= ST_SHIFT;
					end
				end
				ST_SHIFT: begin
					if (mono_done) begin
						data_out <= 1'b1;
						state <= ST_IDLE;
					end else if (clk_rise) begin
						if (bit_idx == IMAX) begin
							data_out <= 1'b0;
							bit_idx <= '0;
						end else begin
							data_out <= shift_word[BITS-1];
							shift_word <= {shift_word[BITS-2:0], shift_word[BITS-1]};
							bit_idx <= bit_idx + 1'b1;
						end
					end
				end
			endcase
		end
	end

	assign link.ssi_data = data_out;

	////////////////////////////////////////////////////////////////////////////
	// Indicators. Green is lit out of reset and goes dark while the preset key is held.
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			led_green <= 1'b1;
			led_red <= 1'b0;
		end else begin
			led_green <= ~pin_s2[P_KEY];
			led_red <= pin_s2[P_DIAG];
		end
	end
endmodule: sspe_encoder

//--- design/sspe_ctrl.sv
// Purpose: Controller end: AXI4-Lite registers, clock burst generation, word capture.
// Assumes: The encoder answers with the word width set by BITS and the same code.
// Notes: The link clock is a divided copy of core_clk.
//
// The AXI4-Lite slave port and the placing of the registers were chosen for this implementation.
`timescale 1ns/10ps
module sspe_ctrl #(
	parameter int BITS = sspe_pkg::POS_MAX_BITS,
	parameter bit GRAY = 1'b1,
	parameter int HALF = 50
) (
	// Clock and reset.
	input wire logic core_clk,
	input wire logic rstn,
	// AXI4-Lite slave.
	input wire logic [sspe_pkg::ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [sspe_pkg::ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Interrupt.
	output logic irq,
	// Serial link.
	sspe_link_if.ctl link
);
	import sspe_pkg::*;

	if (BITS < 2 || BITS > POS_MAX_BITS || HALF < HALF_MIN || HALF > HALF_MAX) begin : g_bad
		$error("BITS or HALF outside what the link supports");
	end

	localparam int HW = $clog2(HALF);
	localparam int GW = $clog2(MONO_MAX_CYC + 1);
	localparam int NW = $clog2(BITS + 2);
	localparam logic [HW-1:0] HLAST = HW'(HALF - 1);
	localparam logic [GW-1:0] GLAST = GW'(MONO_MAX_CYC);
	localparam logic [NW-1:0] NLAST = NW'(BITS + 1);

	typedef enum logic [2:0] {
		CS_IDLE = 3'b001,
		CS_CLOCK = 3'b010,
		CS_GAP = 3'b100
	} sspe_ctl_state_e;

	sspe_ctl_state_e state;
	logic clk_out;
	logic data_s1;
	logic data_s2;
	logic [HW-1:0] half_cnt;
	logic [GW-1:0] gap_cnt;
	logic [NW-1:0] falls;
	logic [BITS-1:0] rx_word;
	logic [BITS-1:0] pos_word;
	logic done;
	logic aw_hold;
	logic w_hold;
	logic [ADDR_W-1:0] aw_addr;
	logic [31:0] w_data;
	logic w_lane0;
	logic do_write;
	logic start;
	logic irq_stat;
	logic irq_mask;
	logic [31:0] rd_val;
	logic rd_err;
	logic wr_err;
	logic [POS_MAX_BITS-1:0] rx_bin;

	////////////////////////////////////////////////////////////////////////////
	// Write path: address and data are held apart, the response follows both.
	assign do_write = aw_hold & w_hold & ~s_axi_bvalid;
	assign wr_err = !(aw_addr inside {REG_CTRL, REG_STATUS, REG_POS, REG_IRQ_STAT, REG_IRQ_MASK});

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			aw_hold <= 1'b0;
			w_hold <= 1'b0;
			aw_addr <= '0;
			w_data <= '0;
			w_lane0 <= 1'b0;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RESP_OKAY;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_hold <= 1'b1;
				aw_addr <= s_axi_awaddr;
				s_axi_awready <= 1'b0;
			end else if (!aw_hold && !s_axi_bvalid) begin
				s_axi_awready <= 1'b1;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_hold <= 1'b1;
				w_data <= s_axi_wdata;
				w_lane0 <= s_axi_wstrb[0];
				s_axi_wready <= 1'b0;
			end else if (!w_hold && !s_axi_bvalid) begin
				s_axi_wready <= 1'b1;
			end
			if (do_write) begin
				aw_hold <= 1'b0;
				w_hold <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wr_err ? RESP_SLVERR : RESP_OKAY;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Read path.
	always_comb begin
		rd_val = 32'h0000_0000;
		rd_err = 1'b0;
		unique case (s_axi_araddr)
			REG_CTRL: rd_val = 32'h0000_0000;
			REG_STATUS: rd_val[STAT_BUSY_BIT] = (state != CS_IDLE);
			REG_POS: rd_val = 32'(pos_word);
			REG_IRQ_STAT: rd_val[IRQ_DONE_BIT] = irq_stat;
			REG_IRQ_MASK: rd_val[IRQ_DONE_BIT] = irq_mask;
			default: rd_err = 1'b1;
		endcase
	end

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= rd_val;
			s_axi_rresp <= rd_err ? RESP_SLVERR : RESP_OKAY;
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end else if (!s_axi_rvalid && !s_axi_arready) begin
			s_axi_arready <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Control and interrupt registers; a new event beats a clear in the same cycle.
	assign start = do_write & w_lane0 & (aw_addr == REG_CTRL) & w_data[CTRL_START_BIT];

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			irq_stat <= 1'b0;
			irq_mask <= 1'b0;
			irq <= 1'b0;
		end else begin
			if (done) begin
				irq_stat <= 1'b1;
			end else if (do_write && w_lane0 && aw_addr == REG_IRQ_STAT && w_data[IRQ_DONE_BIT]) begin
				irq_stat <= 1'b0;
			end
			if (do_write && w_lane0 && aw_addr == REG_IRQ_MASK) begin
				irq_mask <= w_data[IRQ_DONE_BIT];
			end
			irq <= irq_stat & irq_mask;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Link: BITS+1 clock periods, sampling just before each falling edge but
	// the first; then a pause past the longest monoflop so the next word is fresh.
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			data_s1 <= 1'b1;
			data_s2 <= 1'b1;
		end else begin
			data_s1 <= link.ssi_data;
			data_s2 <= data_s1;
		end
	end

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			state <= CS_IDLE;
			clk_out <= 1'b1;
			half_cnt <= '0;
			gap_cnt <= '0;
			falls <= '0;
			rx_word <= '0;
			pos_word <= '0;
			done <= 1'b0;
		end else begin
			done <= 1'b0;
			unique case (state)
				CS_IDLE: begin
					if (start) begin
						clk_out <= 1'b0;
						half_cnt <= '0;
						falls <= NW'(1);
						state <= CS_CLOCK;
					end
				end
				CS_CLOCK: begin
					half_cnt <= half_cnt + 1'b1;
					if (half_cnt == HLAST) begin
						half_cnt <= '0;
						if (!clk_out) begin
							clk_out <= 1'b1;
							if (falls == NLAST) begin
								gap_cnt <= '0;
								state <= CS_GAP;
							end
						end else begin
							rx_word <= {rx_word[BITS-2:0], data_s2};
							clk_out <= 1'b0;
							falls <= falls + 1'b1;
						end
					end
				end
				CS_GAP: begin
					gap_cnt <= gap_cnt + 1'b1;
					if (gap_cnt == GLAST) begin
						pos_word <= GRAY ? rx_bin[BITS-1:0] : rx_word;
						done <= 1'b1;
						state <= CS_IDLE;
					end
				end
			endcase
		end
	end

	// Leading zeros of the widened word decode to zeros, so the low bits are exact.
	assign rx_bin = gray2bin(POS_MAX_BITS'(rx_word));

	assign link.ssi_clk = clk_out;
endmodule: sspe_ctrl

//--- tb/sspe_link_asserts.sv
// Purpose: Timing checks on the serial position link between both ends.
// Assumes: Both ends run on core_clk; HALF matches the controller.
// Notes: Phase counters measure the link clock in core cycles.
`timescale 1ns/10ps
module sspe_link_asserts #(
	parameter int BITS = 16,
	parameter int HALF = 50
) (
	// Clock and reset.
	input wire logic core_clk,
	input wire logic rstn,
	// Link lines.
	input wire logic ssi_clk,
	input wire logic ssi_data
);
	import sspe_pkg::*;
	localparam int GAP = (MONO_NOM_US + MONO_TOL_US) * CLK_MHZ;
	localparam int TAIL = MONO_CYC - HALF - 10;
	logic [15:0] hi_cnt;
	logic [15:0] lo_cnt;
	logic [5:0] fall_cnt;
	////////////////////////////////////////////////////////////////////////////////
	// The high counter saturates, so a long idle never reads as a short phase.
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			hi_cnt <= 16'hFFFF;
		end else if (!ssi_clk) begin
			hi_cnt <= 16'h0000;
		end else if (hi_cnt != 16'hFFFF) begin
			hi_cnt <= hi_cnt + 16'h0001;
		end
	end
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			lo_cnt <= 16'h0000;
		end else if (ssi_clk) begin
			lo_cnt <= 16'h0000;
		end else begin
			lo_cnt <= lo_cnt + 16'h0001;
		end
	end
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			fall_cnt <= 6'h00;
		end else if (!ssi_clk && hi_cnt != 16'h0000) begin
			// A fall is a low sample after a high one; hi_cnt is zero only after a low.
			fall_cnt <= (hi_cnt > 16'(2 * HALF)) ? 6'h01 : fall_cnt + 6'h01;
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rstn);
	chk_low_phase: assert property ($rose(ssi_clk) |-> lo_cnt == 16'(HALF))
		else $error("link clock low phase has wrong length");
	chk_high_phase: assert property ($fell(ssi_clk) && hi_cnt <= 16'(2 * HALF)
		|-> hi_cnt == 16'(HALF)) else $error("link clock high phase has wrong length");
	chk_fall_count: assert property (hi_cnt == 16'(2 * HALF + 1)
		|-> fall_cnt == 6'(BITS + 1)) else $error("burst has wrong number of falls");
	chk_pause_gap: assert property ($fell(ssi_clk) && hi_cnt > 16'(2 * HALF)
		|-> hi_cnt > 16'(GAP)) else $error("new burst before the pause ran out");
	chk_start_high: assert property ($fell(ssi_clk) && hi_cnt > 16'(2 * HALF)
		|-> ssi_data) else $error("data not high when a burst starts");
	chk_tail_low: assert property (ssi_clk && fall_cnt == 6'(BITS + 1)
		&& hi_cnt > 16'h000A && hi_cnt < 16'(TAIL) |-> !ssi_data)
		else $error("data not low after the last bit");
	chk_idle_high: assert property (hi_cnt > 16'(MONO_CYC) |-> ssi_data)
		else $error("data not high in idle");
	chk_data_edge: assert property ($changed(ssi_data) && hi_cnt < 16'h03E8
		|-> hi_cnt >= 16'h0001 && hi_cnt <= 16'h000A)
		else $error("data changed away from a rising clock");
endmodule: sspe_link_asserts

//--- tb/test_ssi_singleturn_position_encoder.sv
// Purpose: Drives both link ends through registers and side pins.
// Assumes: ZERO_MIN is shortened to 20 cycles for simulation.
// Notes: The wire word is rebuilt from falling link clock edges.
`timescale 1ns/10ps
module test_ssi_singleturn_position_encoder;
	import sspe_pkg::*;
	logic core_clk, rstn, awvalid, wvalid, bready, arvalid, rready;
	logic awready, wready, bvalid, arready, rvalid, irq;
	logic step, step_cw, dir_sel, zero_set, preset_key, diag_fail, led_green, led_red;
	logic [4:0] awaddr, araddr;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp;
	logic [31:0] wdata, rdata, v;
	logic [15:0] position;
	logic [16:0] wsh;
	int bad_count, n_tests, cyc;
	sspe_link_if link();
	sspe_encoder #(.ZERO_MIN(20)) sspe_encoder_inst(.core_clk(core_clk), .rstn(rstn),
		.link(link), .step(step), .step_cw(step_cw), .dir_sel(dir_sel),
		.zero_set(zero_set), .preset_key(preset_key), .diag_fail(diag_fail),
		.led_green(led_green), .led_red(led_red), .position(position));
	sspe_ctrl sspe_ctrl_inst(.core_clk(core_clk), .rstn(rstn), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .irq(irq), .link(link));
	sspe_link_asserts #(.BITS(16), .HALF(50)) sspe_link_asserts_inst(.core_clk(core_clk),
		.rstn(rstn), .ssi_clk(link.ssi_clk), .ssi_data(link.ssi_data));
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		core_clk = 1'h0;
		forever #5 core_clk = ~core_clk;
	end
	always @(negedge link.ssi_clk) begin
		wsh <= {wsh[15:0], link.ssi_data};
	end
	// A hung handshake lands here and still gives one verdict.
	always @(posedge core_clk) begin
		cyc++;
		if (cyc == 30000) begin
			bad_count++;
			complete_run();
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			bad_count++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask: chk
	task automatic wr(input logic [4:0] a, input logic [31:0] d, input logic [1:0] e);
		logic ad, wd;
		ad = 1'h0;
		wd = 1'h0;
		@(posedge core_clk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'h1;
		wvalid <= 1'h1;
		bready <= 1'h1;
		while (!(ad && wd)) begin
			@(posedge core_clk);
			if (awready) begin
				ad = 1'h1;
				awvalid <= 1'h0;
			end
			if (wready) begin
				wd = 1'h1;
				wvalid <= 1'h0;
			end
		end
		do @(posedge core_clk); while (!bvalid);
		bready <= 1'h0;
		chk({30'h0, bresp}, {30'h0, e});
	endtask: wr
	task automatic rd(input logic [4:0] a, output logic [31:0] d, input logic [1:0] e);
		@(posedge core_clk);
		araddr <= a;
		arvalid <= 1'h1;
		rready <= 1'h1;
		do @(posedge core_clk); while (!arready);
		arvalid <= 1'h0;
		do @(posedge core_clk); while (!rvalid);
		d = rdata;
		rready <= 1'h0;
		chk({30'h0, rresp}, {30'h0, e});
	endtask: rd
	task automatic steps(input int n, input logic cw);
		repeat (n) begin
			@(posedge core_clk);
			step <= 1'h1;
			step_cw <= cw;
			@(posedge core_clk);
			step <= 1'h0;
		end
		repeat (4) @(posedge core_clk);
	endtask: steps
	// Runs one burst and checks register, wire word and interrupt together.
	task automatic xfer(input logic [15:0] p, input logic m);
		wr(REG_CTRL, 32'h00000001, RESP_OKAY);
		v = 32'h00000001;
		while (v[0]) rd(REG_STATUS, v, RESP_OKAY);
		rd(REG_POS, v, RESP_OKAY);
		chk(v, {16'h0000, p});
		chk({15'h0000, wsh}, {15'h0000, 1'h1, p ^ (p >> 1)});
		rd(REG_IRQ_STAT, v, RESP_OKAY);
		chk(v, 32'h00000001);
		chk({31'h0, irq}, {31'h0, m});
		wr(REG_IRQ_STAT, 32'h00000001, RESP_OKAY);
		repeat (2) @(posedge core_clk);
		chk({31'h0, irq}, 32'h00000000);
	endtask: xfer
	task automatic complete_run;
		$display("comparisons %0d mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask: complete_run
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		{rstn, awvalid, wvalid, bready, arvalid, rready, step, step_cw} = 8'h00;
		{zero_set, preset_key, diag_fail} = 3'h0;
		dir_sel = 1'h1;
		{awaddr, araddr, wdata} = 42'h0;
		wstrb = 4'hF;
		repeat (3) @(posedge core_clk);
		rstn <= 1'h1;
		repeat (2) @(posedge core_clk);
		chk({31'h0, led_green}, 32'h00000001);
		chk({31'h0, led_red}, 32'h00000000);
		rd(5'h14, v, RESP_SLVERR);
		chk(v, 32'h00000000);
		wr(REG_IRQ_MASK, 32'h00000001, RESP_OKAY);
		// A write without the low byte lane must leave the mask alone.
		wstrb <= 4'hE;
		wr(REG_IRQ_MASK, 32'h00000000, RESP_OKAY);
		wstrb <= 4'hF;
		rd(REG_IRQ_MASK, v, RESP_OKAY);
		chk(v, 32'h00000001);
		$display("test reset done");
		steps(5, 1'h1);
		chk({16'h0000, position}, 32'h00000005);
		xfer(16'h0005, 1'h1);
		$display("test count up done");
		dir_sel <= 1'h0;
		repeat (5) @(posedge core_clk);
		steps(8, 1'h1);
		chk({16'h0000, position}, 32'h0000FFFD);
		steps(1, 1'h0);
		wr(REG_IRQ_MASK, 32'h00000000, RESP_OKAY);
		xfer(16'hFFFE, 1'h0);
		$display("test count down done");
		zero_set <= 1'h1;
		repeat (10) @(posedge core_clk);
		zero_set <= 1'h0;
		repeat (6) @(posedge core_clk);
		chk({16'h0000, position}, 32'h0000FFFE);
		zero_set <= 1'h1;
		repeat (25) @(posedge core_clk);
		zero_set <= 1'h0;
		repeat (6) @(posedge core_clk);
		chk({16'h0000, position}, 32'h00000000);
		$display("test zero set done");
		dir_sel <= 1'h1;
		steps(3, 1'h1);
		preset_key <= 1'h1;
		diag_fail <= 1'h1;
		repeat (6) @(posedge core_clk);
		chk({31'h0, led_green}, 32'h00000000);
		chk({16'h0000, position}, 32'h00000000);
		chk({31'h0, led_red}, 32'h00000001);
		preset_key <= 1'h0;
		repeat (6) @(posedge core_clk);
		chk({31'h0, led_green}, 32'h00000001);
		wr(REG_IRQ_MASK, 32'h00000001, RESP_OKAY);
		xfer(16'h0000, 1'h1);
		$display("test key done");
		complete_run();
	end
endmodule: test_ssi_singleturn_position_encoder
